// ==== rtl/msc_delay.sv ====
// Module: recovery delay counter in tick units
`timescale 1ns/1ps
`default_nettype none
module msc_delay (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic tick,
  input wire logic load,
  input wire logic [7:0] steps,
  output logic busy
);
  logic [7:0] cnt_reg;
  // Load and count down on each tick
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 8'h00;
    end else if (load) begin
      cnt_reg <= steps;
    end else if (tick && cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end
  assign busy = load || (cnt_reg != 8'h00);
endmodule : msc_delay
`default_nettype wire

// ==== rtl/msc_pkg.sv ====
// Package: register map, field layout and timing for measurement scan control
package msc_pkg;
  // Register indices (byte address is four times the index)
  localparam logic [7:0] REG_IDX_DELAY = 8'h63;
  localparam logic [7:0] REG_IDX_EN_ONE = 8'h64;
  localparam logic [7:0] REG_IDX_EN_TWO = 8'h65;
  localparam logic [7:0] REG_IDX_SCAN = 8'h66;
  localparam logic [7:0] REG_IDX_STATUS = 8'h70;
  localparam logic [7:0] REG_IDX_MODE = 8'h71;
  // Reset values
  localparam logic [15:0] RST_DELAY = 16'h0000;
  localparam logic [15:0] RST_EN_ONE = 16'h0000;
  localparam logic [15:0] RST_EN_TWO = 16'h0000;
  localparam logic [15:0] RST_SCAN = 16'h0000;
  localparam logic [15:0] RST_MODE = 16'h0000;
  // Scan control fields
  localparam int SC_DONE = 15;
  localparam int SC_TIMEOUT = 14;
  localparam int SC_READY = 13;
  localparam int SC_SUSPEND = 12;
  localparam int SC_ALERT_FILT = 11;
  localparam int SC_AMEND = 10;
  localparam int SC_READ_FILT = 9;
  localparam int SC_TYPE_LO = 6;
  localparam int SC_OVS_LO = 3;
  localparam int SC_ALT_PATH = 2;
  localparam int SC_ORDER = 1;
  localparam int SC_REQUEST = 0;
  // Enable fields
  localparam int EN_CSA = 15;
  localparam int EN_BLOCK = 14;
  localparam int EN_INIT = 15;
  localparam int CELL_COUNT = 14;
  localparam int AUX_COUNT = 4;
  // Delay fields
  localparam int DLY_CELL_LO = 8;
  localparam int DLY_SW_LO = 0;
  // Mode register fields
  localparam int MD_AUTO_BAL = 0;
  localparam int MD_MEAS_LO = 1;
  localparam int MD_WDOG_DIS = 3;
  // Timing
  localparam int CLK_FREQ_HZ = 250_000_000;
  localparam int TICK_US = 96;
  localparam int TICK_CYCLES = TICK_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int TIMEOUT_BASE_TICKS = 8;
  // Scan types
  typedef enum logic [2:0] {
    MSC_ADC_ONLY, MSC_ADC_COMP, MSC_COMP_ONLY, MSC_CALIBRATE,
    MSC_SW_SHORT, MSC_SW_OPEN, MSC_SENSE_ODD, MSC_SENSE_EVEN
  } msc_scan_type;
  // Scan command passed to the engine
  typedef struct packed {
    msc_scan_type kind;
    logic [2:0] ovs;
    logic ramp;
    logic alt_path;
    logic alert_filt;
    logic amend;
    logic read_filt;
    logic init_iir;
    logic csa_en;
    logic block_en;
    logic [13:0] cells;
    logic [3:0] aux;
  } msc_cmd_type;
endpackage : msc_pkg

// ==== rtl/msc_tick.sv ====
// Module: 96 us tick generator
`timescale 1ns/1ps
`default_nettype none
module msc_tick #(
  parameter int CYCLES = msc_pkg::TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rstn,
  output logic tick
);
  logic [31:0] cnt_reg;
  // Free running prescaler
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 32'h00000000;
      tick <= 1'b0;
    end else if (cnt_reg == 32'(CYCLES - 1)) begin
      cnt_reg <= 32'h00000000;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h00000001;
      tick <= 1'b0;
    end
  end
endmodule : msc_tick
`default_nettype wire

// ==== rtl/msc_top.sv ====
// Module: measurement scan control, Wishbone registers and sequencer
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module msc_top #(
  parameter int TICK_CYCLES = msc_pkg::TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [13:0] cell_bipolar,
  input wire logic [1:0] digital_serial_pin_mode,
  input wire logic [3:0] pin_general_io_mode,
  input wire logic pair_done,
  input wire logic engine_done,
  output logic engine_start,
  output msc_pkg::msc_cmd_type engine_cmd,
  output logic balance_suspend,
  output logic block_divider,
  output logic request_rejected_alert,
  output logic calib_update,
  output logic iir_update
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_RUN, ST_PAIR_WAIT, ST_FINISH} msc_state_type;
  msc_state_type state_reg;
  logic [15:0] delay_reg;
  logic [15:0] en_one_reg;
  logic [15:0] en_two_reg;
  logic [15:0] scan_reg;
  logic [15:0] mode_reg;
  logic done_reg;
  logic timeout_reg;
  logic ready_reg;
  logic [31:0] wd_reg;
  logic [15:0] wd_limit;
  logic tick;
  logic dly_load;
  logic [7:0] dly_steps;
  logic dly_busy;
  logic auto_bal;
  logic req_ok;
  logic req_bad;
  logic wr_scan;
  logic bus_req;
  logic [7:0] idx;
  logic [15:0] wdat;
  logic [15:0] rd_mux;
  msc_pkg::msc_cmd_type cmd_next;
  logic [15:0] scan_wr;
  logic dly_path;

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [3:0] sel);
    merge16 = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
  endfunction : merge16

  // Ticks allowed per oversampling code
  function automatic logic [15:0] ovs_limit(input logic [2:0] ovs);
    logic [2:0] sh;
    sh = (ovs > 3'h6) ? 3'h6 : ovs;
    ovs_limit = 16'(msc_pkg::TIMEOUT_BASE_TICKS) << (sh + 3'h1);
  endfunction : ovs_limit

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign idx = wb_adr_i[9:2];
  assign wr_scan = bus_req && wb_we_i && idx == msc_pkg::REG_IDX_SCAN;
  assign wdat = merge16(16'h0000, wb_dat_i[15:0], wb_sel_i);
  assign scan_wr = merge16(scan_reg, wb_dat_i[15:0], wb_sel_i);
  assign auto_bal = mode_reg[msc_pkg::MD_AUTO_BAL];

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // One-cycle ack for any address
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Read data mux
  always_comb begin
    rd_mux = 16'h0000;
    unique case (idx)
      msc_pkg::REG_IDX_DELAY: rd_mux = delay_reg;
      msc_pkg::REG_IDX_EN_ONE: rd_mux = en_one_reg;
      msc_pkg::REG_IDX_EN_TWO: rd_mux = {en_two_reg[15], 11'h000, en_two_reg[3:0]};
      msc_pkg::REG_IDX_SCAN: rd_mux = {done_reg, timeout_reg, ready_reg, scan_reg[12:1], 1'b0};
      msc_pkg::REG_IDX_STATUS: rd_mux = {13'h0000, dly_busy, state_reg != ST_IDLE, balance_suspend};
      msc_pkg::REG_IDX_MODE: rd_mux = {12'h000, mode_reg[3:0]};
      default: rd_mux = 16'h0000;
    endcase
  end

  // Registered read data
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wb_dat_o <= 32'h00000000;
    end else if (bus_req && !wb_we_i) begin
      wb_dat_o <= {16'h0000, rd_mux};
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // plain storage
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      delay_reg <= msc_pkg::RST_DELAY;
      en_one_reg <= msc_pkg::RST_EN_ONE;
      en_two_reg <= msc_pkg::RST_EN_TWO;
      mode_reg <= msc_pkg::RST_MODE;
    end else if (bus_req && wb_we_i) begin
      if (idx == msc_pkg::REG_IDX_DELAY) begin
        delay_reg <= merge16(delay_reg, wb_dat_i[15:0], wb_sel_i);
      end
      if (idx == msc_pkg::REG_IDX_EN_ONE) begin
        en_one_reg <= merge16(en_one_reg, wb_dat_i[15:0], wb_sel_i);
      end
      if (idx == msc_pkg::REG_IDX_EN_TWO) begin
        en_two_reg <= merge16(en_two_reg, wb_dat_i[15:0], wb_sel_i) & 16'h800F;
      end
      if (idx == msc_pkg::REG_IDX_MODE) begin
        mode_reg <= merge16(mode_reg, wb_dat_i[15:0], wb_sel_i) & 16'h000F;
      end
    end
  end

  // Scan control fields 12..1; written fields kept even on refusal
  // fields accepted always
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      scan_reg <= msc_pkg::RST_SCAN;
    end else if (wr_scan) begin
      scan_reg <= {3'h0, scan_wr[12:1], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // Request handling
  // ----------------------------------------------------------------
  // strobe, refuse while busy or complete
  assign req_ok = wr_scan && wb_sel_i[0] && wb_dat_i[msc_pkg::SC_REQUEST]
                  && state_reg == ST_IDLE && !done_reg;
  assign req_bad = wr_scan && wb_sel_i[0] && wb_dat_i[msc_pkg::SC_REQUEST] && !req_ok;

  // Refusal alert pulse
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      request_rejected_alert <= 1'b0;
    end else begin
      request_rejected_alert <= req_bad;
    end
  end

  // Command built from freshly written fields and enables
  always_comb begin
    logic [15:0] sc;
    sc = merge16(scan_reg, wb_dat_i[15:0], wb_sel_i);
    cmd_next = '0;
    cmd_next.kind = msc_pkg::msc_scan_type'(sc[msc_pkg::SC_TYPE_LO +: 3]);
    cmd_next.ovs = sc[msc_pkg::SC_OVS_LO +: 3];
    cmd_next.ramp = sc[msc_pkg::SC_ORDER];
    cmd_next.alt_path = sc[msc_pkg::SC_ALT_PATH];
    cmd_next.alert_filt = sc[msc_pkg::SC_ALERT_FILT];
    cmd_next.amend = sc[msc_pkg::SC_AMEND];
    cmd_next.read_filt = sc[msc_pkg::SC_READ_FILT];
    cmd_next.init_iir = en_two_reg[msc_pkg::EN_INIT];
    cmd_next.cells = en_one_reg[msc_pkg::CELL_COUNT-1:0];
    cmd_next.csa_en = en_one_reg[msc_pkg::EN_CSA];
    cmd_next.block_en = en_one_reg[msc_pkg::EN_BLOCK];
    cmd_next.aux = en_two_reg[3:0] & ~pin_general_io_mode
                   & ~{2'b00, digital_serial_pin_mode};
    if (auto_bal) begin
      cmd_next.kind = msc_pkg::MSC_ADC_ONLY;
      cmd_next.ovs = 3'h3;
      cmd_next.ramp = 1'b0;
      cmd_next.alert_filt = 1'b1;
      cmd_next.amend = 1'b1;
    end
    if (cmd_next.kind == msc_pkg::MSC_CALIBRATE) begin
      cmd_next.ovs = 3'h0;
      cmd_next.ramp = 1'b0;
      cmd_next.cells = 14'h0000;
      cmd_next.aux = 4'h0;
      cmd_next.csa_en = 1'b0;
      cmd_next.block_en = 1'b0;
    end
    if (cmd_next.kind == msc_pkg::MSC_COMP_ONLY) begin
      cmd_next.csa_en = 1'b0;
      cmd_next.block_en = 1'b0;
      cmd_next.ramp = 1'b0;
      cmd_next.cells = cmd_next.cells & ~cell_bipolar;
    end
    if (cmd_next.kind == msc_pkg::MSC_ADC_COMP) begin
      cmd_next.ramp = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // tick source for delays
  msc_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .tick(tick)
  );

  // delay picked by path select, fresh on a request
  assign dly_path = req_ok ? scan_wr[msc_pkg::SC_ALT_PATH] : scan_reg[msc_pkg::SC_ALT_PATH];
  assign dly_steps = dly_path ? delay_reg[msc_pkg::DLY_SW_LO +: 8]
                              : delay_reg[msc_pkg::DLY_CELL_LO +: 8];
  // manual suspension, auto pair with balancing measure
  assign dly_load = (req_ok && !auto_bal && scan_wr[msc_pkg::SC_SUSPEND])
                    || (state_reg == ST_IDLE && pair_done && auto_bal
                        && mode_reg[msc_pkg::MD_MEAS_LO + 1]);

  msc_delay u_delay (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .tick(tick),
    .load(dly_load),
    .steps(dly_steps),
    .busy(dly_busy)
  );

  // Command capture
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      engine_cmd <= '0;
    end else if (req_ok) begin
      engine_cmd <= cmd_next;
    end
  end

  // Scan state machine
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (req_ok) begin
            state_reg <= ST_DELAY;
          end else if (dly_load) begin
            state_reg <= ST_PAIR_WAIT;
          end
        end
        ST_DELAY: begin
          if (!dly_busy) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (engine_done) begin
            state_reg <= ST_FINISH;
          end else if (!mode_reg[msc_pkg::MD_WDOG_DIS] && wd_reg[15:0] >= wd_limit) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_PAIR_WAIT: begin
          if (!dly_busy) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_FINISH: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Engine start pulse on leaving the delay
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      engine_start <= 1'b0;
    end else begin
      engine_start <= state_reg == ST_DELAY && !dly_busy;
    end
  end

  // watchdog in ticks, limit by oversampling
  assign wd_limit = ovs_limit(engine_cmd.ovs);
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wd_reg <= 32'h00000000;
    end else if (state_reg != ST_RUN) begin
      wd_reg <= 32'h00000000;
    end else if (tick) begin
      wd_reg <= wd_reg + 32'h00000001;
    end
  end

  // suspend and divider for the scan duration
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      balance_suspend <= 1'b0;
      block_divider <= 1'b0;
    end else begin
      balance_suspend <= scan_reg[msc_pkg::SC_SUSPEND] && !auto_bal
                         && (state_reg == ST_DELAY || state_reg == ST_RUN);
      block_divider <= engine_cmd.block_en && state_reg == ST_RUN;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      calib_update <= 1'b0;
      iir_update <= 1'b0;
    end else begin
      calib_update <= state_reg == ST_FINISH && engine_cmd.kind == msc_pkg::MSC_CALIBRATE;
      iir_update <= state_reg == ST_FINISH && engine_cmd.kind != msc_pkg::MSC_CALIBRATE
                    && engine_cmd.amend;
    end
  end

  // ----------------------------------------------------------------
  // Status flags, set wins over a write of zero
  // ----------------------------------------------------------------
  // flags
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      done_reg <= 1'b0;
      timeout_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      if (state_reg == ST_FINISH) begin
        done_reg <= 1'b1;
        ready_reg <= 1'b1;
      end else if (wr_scan && wb_sel_i[1]) begin
        done_reg <= done_reg & wdat[msc_pkg::SC_DONE];
        ready_reg <= ready_reg & wdat[msc_pkg::SC_READY];
      end
      if (state_reg == ST_RUN && !engine_done && !mode_reg[msc_pkg::MD_WDOG_DIS]
          && wd_reg[15:0] >= wd_limit) begin
        timeout_reg <= 1'b1;
      end else if (wr_scan && wb_sel_i[1]) begin
        timeout_reg <= timeout_reg & wdat[msc_pkg::SC_TIMEOUT];
      end
    end
  end
endmodule : msc_top
`default_nettype wire

// ==== verif/msc_top_sva.sv ====
// Checker: port-level assertions for measurement scan control
`timescale 1ns/1ps
`default_nettype none
module msc_top_sva #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [13:0] cell_bipolar,
  input wire logic [1:0] digital_serial_pin_mode,
  input wire logic [3:0] pin_general_io_mode,
  input wire logic engine_done,
  input wire logic engine_start,
  input wire msc_pkg::msc_cmd_type engine_cmd,
  input wire logic balance_suspend,
  input wire logic block_divider,
  input wire logic request_rejected_alert,
  input wire logic calib_update,
  input wire logic iir_update
);
  // ------------------------------
  // Helpers
  // ------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  logic scan_req;
  // Scan request write on the bus
  assign scan_req = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_dat_i[0]
    && (wb_adr_i[9:2] == msc_pkg::REG_IDX_SCAN);
  // One-cycle pulse shape
  sequence s_pulse(sig);
    sig ##1 !sig;
  endsequence
  // Suspension released shortly after completion
  sequence s_release;
    ##[1:3] !balance_suspend;
  endsequence
  // ------------------------------
  // Assertions
  // ------------------------------
  a_reject_shape: assert property (request_rejected_alert |-> s_pulse(request_rejected_alert))
    else $error("reject alert wider than one cycle");
  a_reject_cause: assert property (request_rejected_alert |-> $past(scan_req) || $past(scan_req, 2))
    else $error("reject alert without a request write");
  a_start_shape: assert property (engine_start |-> s_pulse(engine_start))
    else $error("engine start wider than one cycle");
  a_divider_scan: assert property (block_divider |-> engine_cmd.block_en && !(engine_cmd.kind
    inside {msc_pkg::MSC_COMP_ONLY, msc_pkg::MSC_CALIBRATE}))
    else $error("divider on outside an enabled ADC scan");
  a_aux_masked: assert property (engine_start |-> ((engine_cmd.aux[1:0] & digital_serial_pin_mode)
    == 2'b00) && ((engine_cmd.aux & pin_general_io_mode) == 4'h0))
    else $error("aux input enabled while its pin is in another mode");
  a_comp_skip: assert property (engine_start && engine_cmd.kind == msc_pkg::MSC_COMP_ONLY |->
    ((engine_cmd.cells & cell_bipolar) == 14'h0000) && !engine_cmd.csa_en)
    else $error("comparator scan includes bipolar cell or current sense");
  a_ramp_ignored: assert property (engine_start && engine_cmd.kind inside {msc_pkg::MSC_ADC_COMP,
    msc_pkg::MSC_COMP_ONLY, msc_pkg::MSC_CALIBRATE} |-> !engine_cmd.ramp)
    else $error("ramp order on comparator or calibration scan");
  a_calib_end: assert property (calib_update |-> engine_cmd.kind == msc_pkg::MSC_CALIBRATE &&
    ($past(engine_done) || $past(engine_done, 2) || $past(engine_done, 3)))
    else $error("calibration update outside calibration end");
  a_amend_end: assert property (iir_update |-> engine_cmd.amend &&
    ($past(engine_done) || $past(engine_done, 2) || $past(engine_done, 3)))
    else $error("filter update without amend at scan end");
  a_suspend_end: assert property (engine_done && balance_suspend |-> s_release)
    else $error("balancing still suspended after scan end");
endmodule : msc_top_sva
bind msc_top msc_top_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
  .clk_sys(clk_sys), .rstn(rstn), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .cell_bipolar(cell_bipolar), .digital_serial_pin_mode(digital_serial_pin_mode),
  .pin_general_io_mode(pin_general_io_mode), .engine_done(engine_done),
  .engine_start(engine_start), .engine_cmd(engine_cmd), .balance_suspend(balance_suspend),
  .block_divider(block_divider), .request_rejected_alert(request_rejected_alert),
  .calib_update(calib_update), .iir_update(iir_update)
);
`default_nettype wire

// ==== verif/tb_top.sv ====
// Testbench: register access and scan sequencing of scan control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ------------------------------
  // Signals and instance
  // ------------------------------
  logic clk_sys, rstn, cyc, stb, we, eng_done, pair_done, ack, est, bsus, bdiv, rej, cal, iir;
  logic [31:0] adr, dat, rd;
  logic [3:0] sel, gpio;
  logic [1:0] dsp;
  logic [13:0] bip;
  logic [15:0] q;
  msc_pkg::msc_cmd_type cmd, cmd_q;
  int num_errors, n_tests, cnt_cyc, t_start;
  int evt[4];
  msc_top #(.TICK_CYCLES(4)) dut (
    .clk_sys(clk_sys), .rstn(rstn), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rd), .wb_ack_o(ack),
    .cell_bipolar(bip), .digital_serial_pin_mode(dsp), .pin_general_io_mode(gpio),
    .pair_done(pair_done), .engine_done(eng_done), .engine_start(est), .engine_cmd(cmd),
    .balance_suspend(bsus), .block_divider(bdiv), .request_rejected_alert(rej),
    .calib_update(cal), .iir_update(iir)
  );
  // Clock at 4 ns period
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Event counters: start, reject, calibration, filter update
  always @(posedge clk_sys) begin
    cnt_cyc++;
    if (est === 1'b1) begin
      evt[0]++;
      cmd_q = cmd;
      t_start = cnt_cyc;
    end
    if (rej === 1'b1) evt[1]++;
    if (cal === 1'b1) evt[2]++;
    if (iir === 1'b1) evt[3]++;
  end
  // ------------------------------
  // Shared tasks
  // ------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Classic single bus cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] i, input logic [15:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {22'h000000, i, 2'b00};
    dat <= {16'h0000, d};
    @(posedge clk_sys);
    while (ack !== 1'b1) begin
      @(posedge clk_sys);
    end
    q = rd[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_sys);
  endtask : wb
  task automatic wait_evt(input int k, input int old);
    int n;
    n = 0;
    while (evt[k] == old && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    chk("event", evt[k] != old, 1'b1);
  endtask : wait_evt
  task automatic fin();
    eng_done <= 1'b1;
    @(posedge clk_sys);
    eng_done <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : fin
  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_regs();
    logic [7:0] ix[5] = '{8'h63, 8'h64, 8'h65, 8'h66, 8'h71};
    foreach (ix[i]) begin
      wb(1'b0, ix[i], 16'h0000);
      chk("reset", q, 16'h0000);
    end
    wb(1'b1, 8'h40, 16'hFFFF);
    wb(1'b0, 8'h40, 16'h0000);
    chk("unmapped", q, 16'h0000);
    wb(1'b1, 8'h64, 16'hFFFF);
    sel <= 4'h1;
    wb(1'b1, 8'h64, 16'h1234);
    sel <= 4'h3;
    wb(1'b0, 8'h64, 16'h0000);
    chk("lane", q, 16'hFF34);
    wb(1'b1, 8'h65, 16'h800F);
    wb(1'b0, 8'h65, 16'h0000);
    chk("aux read", q, 16'h800F);
    wb(1'b1, 8'h63, 16'h0501);
    wb(1'b0, 8'h63, 16'h0000);
    chk("delay", q, 16'h0501);
    wb(1'b1, 8'h66, 16'hFFFE);
    wb(1'b0, 8'h66, 16'h0000);
    chk("write one", q, 16'h1FFE);
    wb(1'b1, 8'h66, 16'h0000);
    $display("register test done");
  endtask : t_regs
  task automatic t_adc();
    int e, s;
    wb(1'b1, 8'h64, 16'h7FFF);
    e = evt[0];
    wb(1'b1, 8'h66, 16'h0601);
    wait_evt(0, e);
    s = evt[0];
    repeat (2) @(posedge clk_sys);
    chk("cells", cmd_q.cells, 14'h3FFF);
    chk("aux", cmd_q.aux, 4'hA);
    chk("init", cmd_q.init_iir, 1'b1);
    chk("readback_source_select", cmd_q.read_filt, 1'b1);
    chk("divider", bdiv, 1'b1);
    e = evt[1];
    wb(1'b1, 8'h66, 16'h0601);
    wait_evt(1, e);
    e = evt[3];
    fin();
    wait_evt(3, e);
    wb(1'b0, 8'h66, 16'h0000);
    chk("flags", q, 16'hA600);
    e = evt[1];
    wb(1'b1, 8'h66, 16'hE401);
    wait_evt(1, e);
    wb(1'b0, 8'h66, 16'h0000);
    chk("kept", q, 16'hA400);
    wb(1'b1, 8'h66, 16'h0000);
    wb(1'b0, 8'h66, 16'h0000);
    chk("cleared", q, 16'h0000);
    chk("starts", evt[0], s);
    $display("adc test done");
  endtask : t_adc
  task automatic t_types();
    int e;
    bip <= 14'h0005;
    wb(1'b1, 8'h64, 16'hFFFF);
    for (int k = 0; k < 8; k++) begin
      e = evt[0];
      wb(1'b1, 8'h66, {7'h00, k[2:0], 6'h03});
      wait_evt(0, e);
      repeat (2) @(posedge clk_sys);
      chk("kind", cmd_q.kind, k[2:0]);
      if (k < 4) chk("ramp", cmd_q.ramp, k == 0);
      if (k < 4) chk("divider", bdiv, k < 2);
      if (k == 2) chk("bipolar", cmd_q.cells, 14'h3FFA);
      if (k == 2) chk("csa", cmd_q.csa_en, 1'b0);
      e = evt[2];
      fin();
      if (k == 3) wait_evt(2, e);
      wb(1'b0, 8'h66, 16'h0000);
      chk("done", q[15], 1'b1);
      wb(1'b1, 8'h66, 16'h0000);
    end
    bip <= 14'h0000;
    $display("scan type test done");
  endtask : t_types
  task automatic t_delay();
    int e, t;
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, 8'h64, {1'b1, i[0], 14'h3FFF});
      e = evt[0];
      wb(1'b1, 8'h66, {13'h0200, i[0], 2'b01});
      t = cnt_cyc;
      wait_evt(0, e);
      chk("suspend", bsus, 1'b1);
      t = t_start - t - (i == 1 ? 4 : 20);
      chk("span", t >= -3 && t <= 8, 1'b1);
      @(posedge clk_sys);
      chk("block alt", bdiv, i[0]);
      fin();
      chk("resume", bsus, 1'b0);
      wb(1'b1, 8'h66, 16'h0000);
    end
    $display("delay test done");
  endtask : t_delay
  task automatic t_auto();
    int e;
    wb(1'b1, 8'h71, 16'h0001);
    e = evt[0];
    wb(1'b1, 8'h66, 16'h0083);
    wait_evt(0, e);
    chk("kind", cmd_q.kind, msc_pkg::MSC_ADC_ONLY);
    chk("ovs", cmd_q.ovs, 3'b011);
    chk("ramp", cmd_q.ramp, 1'b0);
    chk("alert", cmd_q.alert_filt, 1'b1);
    chk("amend", cmd_q.amend, 1'b1);
    fin();
    wb(1'b1, 8'h66, 16'h0000);
    wb(1'b1, 8'h71, 16'h0005);
    pair_done <= 1'b1;
    @(posedge clk_sys);
    pair_done <= 1'b0;
    wb(1'b0, 8'h70, 16'h0000);
    chk("pair wait", q[2], 1'b1);
    repeat (40) @(posedge clk_sys);
    wb(1'b0, 8'h70, 16'h0000);
    chk("pair end", q[2], 1'b0);
    $display("auto test done");
  endtask : t_auto
  task automatic t_tmo();
    int e;
    for (int w = 0; w < 2; w++) begin
      wb(1'b1, 8'h71, {12'h000, w[0], 3'b000});
      e = evt[0];
      wb(1'b1, 8'h66, 16'h0001);
      wait_evt(0, e);
      chk("reinit", cmd_q.init_iir, 1'b1);
      repeat (100) @(posedge clk_sys);
      wb(1'b0, 8'h66, 16'h0000);
      chk("timeout", q[15:14], w == 1 ? 2'b00 : 2'b01);
      if (w == 0) wb(1'b1, 8'h65, 16'h800F);
      if (w == 1) fin();
      wb(1'b1, 8'h66, 16'h0000);
    end
    $display("timeout test done");
  endtask : t_tmo
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  // Reset, then the scenarios in order
  initial begin
    {rstn, cyc, stb, we, eng_done, pair_done} = 6'h00;
    adr = 32'h00000000;
    dat = 32'h00000000;
    sel = 4'h3;
    dsp = 2'b01;
    gpio = 4'h4;
    bip = 14'h0000;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    t_regs();
    t_adc();
    t_types();
    t_delay();
    t_auto();
    t_tmo();
    results();
  end
  // Watchdog against a hung sequence
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    results();
  end
endmodule : tb_top
`default_nettype wire
